// >>> ftae_defines.svh
`ifndef FTAE_DEFINES_SVH
`define FTAE_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FTAE_OFS_PTR_LO     8'h00
`define FTAE_OFS_PTR_HI     8'h04
`define FTAE_OFS_PTR_UP     8'h08
`define FTAE_OFS_LATCH      8'h0c
`define FTAE_OFS_CTRL       8'h10
`define FTAE_OFS_KEY        8'h14
`define FTAE_OFS_TCMD       8'h18
`define FTAE_OFS_STAT       8'h1c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FTAE_CTRL_WR        1
`define FTAE_CTRL_WRITE_ENABLE_BIT      2
`define FTAE_CTRL_WRITE_ABORT_FLAG     3
`define FTAE_CTRL_FREE      4
`define FTAE_TCMD_DIR       0
`define FTAE_TCMD_MODE_LSB  1
`define FTAE_STAT_BUSY      0
`define FTAE_STAT_TBL       1
`define FTAE_UP_W           6
`define FTAE_ROW_LSB        10

// ----------------------------------------------------------------
// Values and timing
// ----------------------------------------------------------------
`define FTAE_KEY1           8'h55
`define FTAE_KEY2           8'haa
`define FTAE_RESP_OKAY      2'h0
`define FTAE_RESP_SLVERR    2'h2
`define FTAE_HOLD_N         64
`define FTAE_CLK_PERIOD_NS  40
`define FTAE_PROG_TIME_NS   1000000
`define FTAE_PROG_CYCLES    ((`FTAE_PROG_TIME_NS + `FTAE_CLK_PERIOD_NS - 1) / `FTAE_CLK_PERIOD_NS)

`endif

// >>> ftae_pkg.sv
package ftae_pkg;

   typedef enum logic [1:0] {
      FTAE_PM_KEEP     = 2'h0,
      FTAE_PM_POST_INC = 2'h1,
      FTAE_PM_POST_DEC = 2'h2,
      FTAE_PM_PRE_INC  = 2'h3
   } ftae_pmode_e;

   typedef enum logic [1:0] {
      FTAE_UL_IDLE = 2'h0,
      FTAE_UL_KEY1 = 2'h1,
      FTAE_UL_OPEN = 2'h2
   } ftae_unlock_e;

   typedef enum logic [1:0] {
      FTAE_TB_IDLE  = 2'h0,
      FTAE_TB_ISSUE = 2'h1,
      FTAE_TB_CAPT  = 2'h2
   } ftae_tbl_e;

endpackage : ftae_pkg

// >>> ftae_prog_timer.sv
module ftae_prog_timer #(
   parameter int unsigned CYCLES = 25000
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic ce,
   input  wire logic start,
   output logic      busy,
   output logic      done
);

   localparam int unsigned CW = $clog2(CYCLES + 1);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;

   // Start while running is ignored; the caller never restarts a live cycle
   always_comb begin
      cnt_nxt = cnt_r;
      if (start && cnt_r == '0) begin
         cnt_nxt = CW'(CYCLES);
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - CW'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= '0;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
      end
   end

   assign busy = (cnt_r != '0);
   assign done = (cnt_r == CW'(1));

endmodule : ftae_prog_timer

// >>> ftae_flash_table.sv
// Contract
// - Pointer is upper:high:low bytes, 22 bits
// - Low 21 bits address program space
// - Top bit selects identification/configuration space
// - Auto adjust touches only low 21 bits
// - Four modes: keep, post-inc, post-dec, pre-inc
// - Table read copies pointed byte to latch
// - Table write stores latch in holding register
// - Program start takes block from bits 21:10
// - Row erase uses bits 21:10, ignores 9:0
// - One byte per table read
// - Pointer bit 0 picks word byte
// - Erase unit is 1024 bytes, never word
// - No bulk erase from running code
// - Erase needs enable, select and unlock keys
// - Stall execution until programming timer expires
// - Start bit set only, hardware clears
// - Hardware clears erase select on completion
// - Abort flag on reset during a timed cycle or improper start
// - Key register stores nothing, reads zero
`include "ftae_defines.svh"

module ftae_flash_table #(
   parameter int unsigned PROG_CYCLES = `FTAE_PROG_CYCLES,
   parameter int unsigned HOLD_N      = `FTAE_HOLD_N
) (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic                      ce,
   input  wire logic [7:0]                s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [7:0]                s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   output logic                           mem_rd_en,
   output logic [19:0]                    mem_word_addr,
   output logic                           mem_cfg_sel,
   input  wire logic [15:0]               mem_rdata,
   output logic                           erase_req,
   output logic                           prog_req,
   output logic [11:0]                    row_addr,
   output logic                           cpu_stall,
   input  wire logic [$clog2(HOLD_N)-1:0] hold_idx,
   output logic [7:0]                     hold_byte
);

   localparam int unsigned HW = $clog2(HOLD_N);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [21:0] ftae_adj(input logic [21:0] p, input logic dec);
      ftae_adj = {p[21], dec ? 21'(p[20:0] - 21'h1) : 21'(p[20:0] + 21'h1)};
   endfunction : ftae_adj

   function automatic logic ftae_hit(input logic [7:0] a);
      ftae_hit = (a[7:5] == 3'h0) && (a[1:0] == 2'h0);
   endfunction : ftae_hit

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic                 aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt;
   logic [7:0]           aw_addr_r, aw_addr_nxt;
   logic [31:0]          w_data_r, w_data_nxt;
   logic [3:0]           w_strb_r, w_strb_nxt;
   logic                 awready_r, awready_nxt, wready_r, wready_nxt;
   logic                 bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic                 arready_r, arready_nxt;
   logic [1:0]           bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0]          rdata_r, rdata_nxt;
   logic [21:0]          ptr_r, ptr_nxt;
   logic [7:0]           latch_r, latch_nxt;
   logic                 wr_r, wr_nxt, write_enable_bit_r, write_enable_bit_nxt, free_r, free_nxt;
   logic                 write_abort_flag_r, write_abort_flag_nxt, erase_op_r, erase_op_nxt;
   logic                 rst_d_r, rst_d_nxt, stall_r, stall_nxt;
   ftae_pkg::ftae_unlock_e ul_r, ul_nxt;
   ftae_pkg::ftae_tbl_e  tbl_r, tbl_nxt;
   logic                 byte_sel_r, byte_sel_nxt;
   logic                 rd_en_r, rd_en_nxt, cfg_r, cfg_nxt;
   logic [19:0]          maddr_r, maddr_nxt;
   logic                 erase_req_r, erase_req_nxt, prog_req_r, prog_req_nxt;
   logic [11:0]          row_r, row_nxt;
   logic [7:0]           hold_q_r;
   logic [7:0]           hold_mem [HOLD_N];
   logic                 hold_we;
   logic [HW-1:0]        hold_wi;
   logic                 wr_fire, lane0, refuse, tcmd_go, ctrl_go, start_ok;
   ftae_pkg::ftae_pmode_e cmd_mode;
   logic [21:0]          op_addr;
   logic [31:0]          ctrl_rd;
   logic [7:0]           wd;
   logic                 tmr_busy, tmr_done;

   ftae_prog_timer #(
      .CYCLES (PROG_CYCLES)
   ) u_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .start   (start_ok),
      .busy    (tmr_busy),
      .done    (tmr_done)
   );

   // ----------------------------------------------------------------
   // Write decode shared by bus and core
   // ----------------------------------------------------------------
   always_comb begin
      wd       = w_data_r[7:0];
      wr_fire  = aw_ok_r && w_ok_r && !bvalid_r;
      lane0    = w_strb_r[0];
      cmd_mode = ftae_pkg::ftae_pmode_e'(wd[`FTAE_TCMD_MODE_LSB +: 2]);
      // Table access is refused while a timed cycle or a read is live
      refuse   = ((aw_addr_r == `FTAE_OFS_TCMD) && (wr_r || tbl_r != ftae_pkg::FTAE_TB_IDLE))
              || ((aw_addr_r == `FTAE_OFS_CTRL) && wr_r);
      tcmd_go  = wr_fire && lane0 && !refuse && aw_addr_r == `FTAE_OFS_TCMD;
      ctrl_go  = wr_fire && lane0 && !refuse && aw_addr_r == `FTAE_OFS_CTRL;
      start_ok = ctrl_go && wd[`FTAE_CTRL_WR] && wd[`FTAE_CTRL_WRITE_ENABLE_BIT]
              && ul_r == ftae_pkg::FTAE_UL_OPEN;
      op_addr  = (cmd_mode == ftae_pkg::FTAE_PM_PRE_INC) ? ftae_adj(ptr_r, 1'b0) : ptr_r;
      ctrl_rd  = 32'h0;
      ctrl_rd[`FTAE_CTRL_WR]    = wr_r;
      ctrl_rd[`FTAE_CTRL_WRITE_ENABLE_BIT]  = write_enable_bit_r;
      ctrl_rd[`FTAE_CTRL_WRITE_ABORT_FLAG] = write_abort_flag_r;
      ctrl_rd[`FTAE_CTRL_FREE]  = free_r;
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   always_comb begin
      aw_ok_nxt   = aw_ok_r;
      aw_addr_nxt = aw_addr_r;
      w_ok_nxt    = w_ok_r;
      w_data_nxt  = w_data_r;
      w_strb_nxt  = w_strb_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      rvalid_nxt  = rvalid_r;
      rresp_nxt   = rresp_r;
      rdata_nxt   = rdata_r;
      if (s_axi_awvalid && awready_r) begin
         aw_ok_nxt   = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
         w_ok_nxt   = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (wr_fire) begin
         aw_ok_nxt  = 1'b0;
         w_ok_nxt   = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt  = (!ftae_hit(aw_addr_r) || refuse) ? `FTAE_RESP_SLVERR : `FTAE_RESP_OKAY;
      end
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && arready_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = ftae_hit(s_axi_araddr) ? `FTAE_RESP_OKAY : `FTAE_RESP_SLVERR;
         unique case (s_axi_araddr)
            `FTAE_OFS_PTR_LO: rdata_nxt = {24'h0, ptr_r[7:0]};
            `FTAE_OFS_PTR_HI: rdata_nxt = {24'h0, ptr_r[15:8]};
            `FTAE_OFS_PTR_UP: rdata_nxt = {26'h0, ptr_r[21:16]};
            `FTAE_OFS_LATCH:  rdata_nxt = {24'h0, latch_r};
            `FTAE_OFS_CTRL:   rdata_nxt = ctrl_rd;
            `FTAE_OFS_STAT:   rdata_nxt = {30'h0, tbl_r != ftae_pkg::FTAE_TB_IDLE, wr_r};
            default:          rdata_nxt = 32'h0;
         endcase
      end
      awready_nxt = !aw_ok_nxt;
      wready_nxt  = !w_ok_nxt;
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ok_r   <= 1'b0;
         aw_addr_r <= 8'h0;
         w_ok_r    <= 1'b0;
         w_data_r  <= 32'h0;
         w_strb_r  <= 4'h0;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         arready_r <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= 2'h0;
         rvalid_r  <= 1'b0;
         rresp_r   <= 2'h0;
         rdata_r   <= 32'h0;
      end else if (ce) begin
         aw_ok_r   <= aw_ok_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_ok_r    <= w_ok_nxt;
         w_data_r  <= w_data_nxt;
         w_strb_r  <= w_strb_nxt;
         awready_r <= awready_nxt;
         wready_r  <= wready_nxt;
         arready_r <= arready_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         rvalid_r  <= rvalid_nxt;
         rresp_r   <= rresp_nxt;
         rdata_r   <= rdata_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Pointer, table access, unlock and timed cycle
   // ----------------------------------------------------------------
   always_comb begin
      ptr_nxt       = ptr_r;
      latch_nxt     = latch_r;
      wr_nxt        = wr_r;
      write_enable_bit_nxt      = write_enable_bit_r;
      free_nxt      = free_r;
      write_abort_flag_nxt     = write_abort_flag_r;
      erase_op_nxt  = erase_op_r;
      stall_nxt     = stall_r;
      ul_nxt        = ul_r;
      tbl_nxt       = tbl_r;
      byte_sel_nxt  = byte_sel_r;
      rd_en_nxt     = 1'b0;
      cfg_nxt       = cfg_r;
      maddr_nxt     = maddr_r;
      erase_req_nxt = 1'b0;
      prog_req_nxt  = 1'b0;
      row_nxt       = row_r;
      rst_d_nxt     = 1'b0;
      hold_we       = 1'b0;
      hold_wi       = op_addr[HW-1:0];
      unique case (tbl_r)
         ftae_pkg::FTAE_TB_IDLE:  tbl_nxt = tbl_r;
         ftae_pkg::FTAE_TB_ISSUE: tbl_nxt = ftae_pkg::FTAE_TB_CAPT;
         ftae_pkg::FTAE_TB_CAPT: begin
            latch_nxt = byte_sel_r ? mem_rdata[15:8] : mem_rdata[7:0];
            tbl_nxt   = ftae_pkg::FTAE_TB_IDLE;
         end
         default: tbl_nxt = ftae_pkg::FTAE_TB_IDLE;
      endcase
      if (wr_fire) begin
         // Any other write between the keys breaks the unlock
         ul_nxt = ftae_pkg::FTAE_UL_IDLE;
      end
      if (wr_fire && lane0 && !refuse) begin
         unique case (aw_addr_r)
            `FTAE_OFS_PTR_LO: ptr_nxt[7:0]   = wd;
            `FTAE_OFS_PTR_HI: ptr_nxt[15:8]  = wd;
            `FTAE_OFS_PTR_UP: ptr_nxt[21:16] = wd[`FTAE_UP_W-1:0];
            `FTAE_OFS_LATCH:  latch_nxt      = wd;
            `FTAE_OFS_KEY: begin
               // Keys pass straight into the sequencer and are never stored
               if (wd == `FTAE_KEY1) begin
                  ul_nxt = ftae_pkg::FTAE_UL_KEY1;
               end else if (wd == `FTAE_KEY2 && ul_r == ftae_pkg::FTAE_UL_KEY1) begin
                  ul_nxt = ftae_pkg::FTAE_UL_OPEN;
               end
            end
            default: ;
         endcase
      end
      if (ctrl_go) begin
         write_enable_bit_nxt  = wd[`FTAE_CTRL_WRITE_ENABLE_BIT];
         free_nxt  = wd[`FTAE_CTRL_FREE];
         write_abort_flag_nxt = wd[`FTAE_CTRL_WRITE_ABORT_FLAG];
         if (start_ok) begin
            wr_nxt        = 1'b1;
            write_abort_flag_nxt     = 1'b1;
            stall_nxt     = 1'b1;
            erase_op_nxt  = wd[`FTAE_CTRL_FREE];
            // Only a single row is ever erased from here
            row_nxt       = ptr_r[21:`FTAE_ROW_LSB];
            erase_req_nxt = wd[`FTAE_CTRL_FREE];
            prog_req_nxt  = !wd[`FTAE_CTRL_FREE];
         end else if (wd[`FTAE_CTRL_WR]) begin
            write_abort_flag_nxt = 1'b1;
         end
      end
      if (tcmd_go) begin
         unique case (cmd_mode)
            ftae_pkg::FTAE_PM_KEEP:     ptr_nxt = ptr_r;
            ftae_pkg::FTAE_PM_POST_DEC: ptr_nxt = ftae_adj(ptr_r, 1'b1);
            ftae_pkg::FTAE_PM_POST_INC,
            ftae_pkg::FTAE_PM_PRE_INC:  ptr_nxt = ftae_adj(ptr_r, 1'b0);
         endcase
         if (wd[`FTAE_TCMD_DIR]) begin
            hold_we = 1'b1;
         end else begin
            tbl_nxt      = ftae_pkg::FTAE_TB_ISSUE;
            rd_en_nxt    = 1'b1;
            maddr_nxt    = op_addr[20:1];
            cfg_nxt      = op_addr[21];
            byte_sel_nxt = op_addr[0];
         end
      end
      if (tmr_done) begin
         wr_nxt    = 1'b0;
         write_abort_flag_nxt = 1'b0;
         stall_nxt = 1'b0;
         if (erase_op_r) begin
            free_nxt = 1'b0;
         end
      end
      if (!aresetn) begin
         // A reset landing in a timed cycle leaves the abort flag up
         rst_d_nxt = 1'b1;
         if (wr_r) begin
            write_abort_flag_nxt = 1'b1;
         end else if (!rst_d_r) begin
            write_abort_flag_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ptr_r       <= 22'h0;
         latch_r     <= 8'h0;
         wr_r        <= 1'b0;
         write_enable_bit_r      <= 1'b0;
         free_r      <= 1'b0;
         write_abort_flag_r     <= write_abort_flag_nxt;
         erase_op_r  <= 1'b0;
         stall_r     <= 1'b0;
         rst_d_r     <= 1'b1;
         ul_r        <= ftae_pkg::FTAE_UL_IDLE;
         tbl_r       <= ftae_pkg::FTAE_TB_IDLE;
         byte_sel_r  <= 1'b0;
         rd_en_r     <= 1'b0;
         cfg_r       <= 1'b0;
         maddr_r     <= 20'h0;
         erase_req_r <= 1'b0;
         prog_req_r  <= 1'b0;
         row_r       <= 12'h0;
      end else if (ce) begin
         ptr_r       <= ptr_nxt;
         latch_r     <= latch_nxt;
         wr_r        <= wr_nxt;
         write_enable_bit_r      <= write_enable_bit_nxt;
         free_r      <= free_nxt;
         write_abort_flag_r     <= write_abort_flag_nxt;
         erase_op_r  <= erase_op_nxt;
         stall_r     <= stall_nxt;
         rst_d_r     <= rst_d_nxt;
         ul_r        <= ul_nxt;
         tbl_r       <= tbl_nxt;
         byte_sel_r  <= byte_sel_nxt;
         rd_en_r     <= rd_en_nxt;
         cfg_r       <= cfg_nxt;
         maddr_r     <= maddr_nxt;
         erase_req_r <= erase_req_nxt;
         prog_req_r  <= prog_req_nxt;
         row_r       <= row_nxt;
      end
   end

   // Holding registers keep their contents across reset and cycles
   always_ff @(posedge aclk) begin
      if (ce && hold_we) begin
         hold_mem[hold_wi] <= latch_r;
      end
      if (!aresetn) begin
         hold_q_r <= 8'h0;
      end else if (ce) begin
         hold_q_r <= hold_mem[hold_idx];
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;
   assign mem_rd_en     = rd_en_r;
   assign mem_word_addr = maddr_r;
   assign mem_cfg_sel   = cfg_r;
   assign erase_req     = erase_req_r;
   assign prog_req      = prog_req_r;
   assign row_addr      = row_r;
   assign cpu_stall     = stall_r;
   assign hold_byte     = hold_q_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !ce);

   sequence s_rd_go;
      tcmd_go && !wd[`FTAE_TCMD_DIR];
   endsequence
   sequence s_rd_issue;
      rd_en_r ##1 tbl_r == ftae_pkg::FTAE_TB_CAPT;
   endsequence

   property p_top_kept;
      tcmd_go |=> ptr_r[21] == $past(ptr_r[21]);
   endproperty
   a_top_kept: assert property (p_top_kept) else $error("pointer top bit moved");

   property p_post_dec;
      tcmd_go && cmd_mode == ftae_pkg::FTAE_PM_POST_DEC
         |=> ptr_r[20:0] == 21'($past(ptr_r[20:0]) - 21'h1);
   endproperty
   a_post_dec: assert property (p_post_dec) else $error("post-decrement wrong");

   property p_read_addr;
      (s_rd_go and (cmd_mode == ftae_pkg::FTAE_PM_KEEP))
         |=> rd_en_r && {mem_cfg_sel, mem_word_addr, byte_sel_r} == $past(ptr_r);
   endproperty
   a_read_addr: assert property (p_read_addr) else $error("read address wrong");

   property p_read_byte;
      s_rd_issue |=> latch_r == ($past(byte_sel_r) ? $past(mem_rdata[15:8])
                                                    : $past(mem_rdata[7:0]));
   endproperty
   a_read_byte: assert property (p_read_byte) else $error("latch byte wrong");

   property p_hold_wr;
      tcmd_go && wd[`FTAE_TCMD_DIR] && cmd_mode == ftae_pkg::FTAE_PM_KEEP
         |=> hold_mem[$past(ptr_r[HW-1:0])] == $past(latch_r);
   endproperty
   a_hold_wr: assert property (p_hold_wr) else $error("holding write wrong");

   property p_row_sel;
      start_ok && wd[`FTAE_CTRL_FREE]
         |=> erase_req && !prog_req && row_addr == $past(ptr_r[21:10]);
   endproperty
   a_row_sel: assert property (p_row_sel) else $error("erase row wrong");

   property p_stall;
      start_ok |=> (cpu_stall && wr_r) ##1 (tmr_busy == cpu_stall);
   endproperty
   a_stall: assert property (p_stall) else $error("stall not tied to timer");

   property p_free_clr;
      tmr_done && erase_op_r |=> !free_r && !wr_r && !write_abort_flag_r;
   endproperty
   a_free_clr: assert property (p_free_clr) else $error("erase completion wrong");

   property p_key_zero;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == `FTAE_OFS_KEY
         |=> s_axi_rvalid && s_axi_rdata == 32'h0;
   endproperty
   a_key_zero: assert property (p_key_zero) else $error("key read not zero");

   property p_bad_start;
      ctrl_go && wd[`FTAE_CTRL_WR] && ul_r != ftae_pkg::FTAE_UL_OPEN
         |=> !wr_r && write_abort_flag_r && !tmr_busy;
   endproperty
   a_bad_start: assert property (p_bad_start) else $error("locked start ran");

   property p_block;
      wr_fire && wr_r && aw_addr_r == `FTAE_OFS_TCMD
         |=> !rd_en_r && ptr_r == $past(ptr_r) && bresp_r == `FTAE_RESP_SLVERR;
   endproperty
   a_block: assert property (p_block) else $error("table access during cycle");

endmodule : ftae_flash_table

// >>> ftae_mem_model.sv
module ftae_mem_model (
   input  wire logic        aclk,
   input  wire logic        mem_rd_en,
   input  wire logic [19:0] mem_word_addr,
   input  wire logic        mem_cfg_sel,
   output logic      [15:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial mem_rdata = 16'h0;
   // Word is valid only in the cycle after a read; otherwise it toggles so stale data shows
   always @(posedge aclk) begin
      if (mem_rd_en) mem_rdata <= {mem_cfg_sel, mem_word_addr[14:0]};
      else mem_rdata <= ~mem_rdata;
   end
endmodule : ftae_mem_model

// >>> ftae_flash_table_test.sv
module ftae_flash_table_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn = 0, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
   logic s_axi_bready = 1, s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, mem_rd_en, mem_cfg_sel, erase_req, prog_req, cpu_stall;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, hold_byte;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [19:0] mem_word_addr;
   logic [15:0] mem_rdata;
   logic [11:0] row_addr;
   logic [5:0] hold_idx = 0;
   int err_total, checked;
   ftae_flash_table #(.PROG_CYCLES(20)) dut (.aclk, .aresetn, .ce, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_rd_en, .mem_word_addr,
      .mem_cfg_sel, .mem_rdata, .erase_req, .prog_req, .row_addr, .cpu_stall, .hold_idx,
      .hold_byte);
   ftae_mem_model mem (.aclk, .mem_rd_en, .mem_word_addr, .mem_cfg_sel, .mem_rdata);
   initial forever #20 aclk = ~aclk;
   task summarize;
      $display("Comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // --------------------------------------------------------------
   // Bus master: bready and rready stay high throughout
   // --------------------------------------------------------------
   // An edge always passes first, so a response still up from the last call is not taken twice
   task wr(input logic [7:0] a, input logic [31:0] d);
      int k;
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      rs = s_axi_bresp;
      if (k == 40) begin err_total++; summarize(); end
   endtask : wr
   task rd(input logic [7:0] a);
      int k;
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      v = s_axi_rdata; rs = s_axi_rresp;
      if (k == 40) begin err_total++; summarize(); end
   endtask : rd
   task set_ptr(input logic [21:0] p);
      wr(8'h00, {24'h0, p[7:0]}); wr(8'h04, {24'h0, p[15:8]}); wr(8'h08, {26'h0, p[21:16]});
   endtask : set_ptr
   // --------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------
   task t_modes;
      logic [21:0] p, n, a;
      for (int m = 0; m < 4; m++) begin
         p = 22'h3fffff;
         n = (m == 2) ? {p[21], p[20:0] - 21'h1} : (m == 0) ? p : {p[21], p[20:0] + 21'h1};
         a = (m == 3) ? n : p;
         set_ptr(p);
         wr(8'h18, {29'h0, m[1:0], 1'b0});
         for (int k = 0; k < 20; k++) begin rd(8'h1c); if (!v[1]) break; end
         chk(v[1], 1'b0);
         rd(8'h0c); chk(v, {24'h0, a[0] ? {a[21], a[15:9]} : a[8:1]});
         rd(8'h00); n[7:0] = n[7:0] ^ v[7:0]; rd(8'h04); n[15:8] = n[15:8] ^ v[7:0];
         rd(8'h08); n[21:16] = n[21:16] ^ v[5:0];
         chk({10'h0, n}, 32'h0);
      end
   endtask : t_modes
   task t_hold;
      set_ptr(22'h0000c5); wr(8'h0c, 32'h5a); wr(8'h18, 32'h1);
      hold_idx <= 6'h05; repeat (2) @(posedge aclk);
      chk(hold_byte, 8'h5a);
   endtask : t_hold
   task t_improper;
      wr(8'h10, 32'h6); chk(cpu_stall, 1'b0);
      rd(8'h10); chk(v, 32'hc);
      rd(8'h14); chk(v, 32'h0);
      rd(8'h20); chk(rs, 2'h2);
   endtask : t_improper
   task t_erase;
      set_ptr(22'h012345); wr(8'h10, 32'h14); wr(8'h14, 32'h55); wr(8'h14, 32'haa);
      wr(8'h10, 32'h16); chk(cpu_stall, 1'b1);
      chk(erase_req, 1'b1);
      chk(row_addr, 12'h048);
      wr(8'h18, 32'h0); chk(rs, 2'h2);
      for (int k = 0; k < 40 && cpu_stall; k++) @(posedge aclk);
      chk(cpu_stall, 1'b0);
      rd(8'h10); chk(v, 32'h4);
   endtask : t_erase
   // A reset landing inside a program cycle must leave only the abort flag up
   task t_reset;
      set_ptr(22'h2abcde); wr(8'h14, 32'h55); wr(8'h14, 32'haa);
      wr(8'h10, 32'h6); chk(prog_req, 1'b1);
      chk(row_addr, 12'haaf);
      aresetn <= 1'b0; repeat (3) @(posedge aclk);
      aresetn <= 1'b1; repeat (2) @(posedge aclk);
      rd(8'h10); chk(v, 32'h8);
   endtask : t_reset
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_modes(); t_hold(); t_improper(); t_erase(); t_reset();
      summarize();
   end
endmodule : ftae_flash_table_test
